// ---- bench/matrix_switch_serial_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module matrix_switch_serial_control_bench;
	import msw_pkg::*;
	logic clk_in;
	logic nrst_in;
	logic strap;
	logic cmd_valid;
	logic [1:0] cmd_kind;
	logic cmd_dev;
	logic [7:0] cmd_reg;
	logic [2:0] cmd_len;
	logic [31:0] cmd_wdata;
	logic cmd_ready;
	logic rsp_valid;
	logic rsp_nack;
	logic [31:0] rsp_rdata;
	logic [SW_COUNT-1:0] switch_w;
	logic spi_mode;
	int err_count;
	int comparisons;

	// ----------------------------------------
	// Both ends across one link
	// ----------------------------------------
	msw_link_if lk ();
	assign lk.addr_strap = strap;

	// Smallest quarter keeps every transfer short
	msw_host_end #(.QUARTER(3), .CHAIN_LEN(1)) msw_host_end_i (
		.clk_in(clk_in), .nrst_in(nrst_in), .lk(lk),
		.cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind),
		.cmd_dev_in(cmd_dev), .cmd_reg_in(cmd_reg), .cmd_len_in(cmd_len),
		.cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_ready),
		.rsp_valid_out(rsp_valid), .rsp_nack_out(rsp_nack),
		.rsp_rdata_out(rsp_rdata));
	msw_dev_end #(.REG_DEPTH(REG_DEPTH_DEF)) msw_dev_end_i (
		.clk_in(clk_in), .nrst_in(nrst_in), .lk(lk),
		.switch_out(switch_w), .spi_mode_out(spi_mode));
	msw_link_properties msw_link_properties_i (
		.clk_in(clk_in), .nrst_in(nrst_in), .scl(lk.scl), .cs_n(lk.cs_n),
		.host_sda_oe(lk.host_sda_oe), .dev_sda_oe(lk.dev_sda_oe),
		.dev_do_out(lk.dev_do_out), .dev_do_oe(lk.dev_do_oe), .sda(lk.sda));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic run_cmd(input logic [1:0] kind, input logic dev,
		input logic [7:0] rg, input logic [2:0] len, input logic [31:0] wd);
		int n;
		n = 0;
		@(negedge clk_in);
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
		cmd_valid <= 1'b1;
		cmd_kind <= kind;
		cmd_dev <= dev;
		cmd_reg <= rg;
		cmd_len <= len;
		cmd_wdata <= wd;
		@(posedge clk_in);
		cmd_valid <= 1'b0;
		n = 0;
		@(negedge clk_in);
		while (rsp_valid !== 1'b1 && n < 5000) begin
			@(negedge clk_in);
			n++;
		end
		check({31'h0, rsp_valid}, 32'h0000_0001);
	endtask

	task automatic nack_is(input logic exp);
		check({31'h0, rsp_nack}, {31'h0, exp});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset_state();
		int n;
		n = 0;
		// Link side settles only after the host's wake-up SCL periods
		while (cmd_ready !== 1'b1 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
		check(switch_w, SR_RESET);
		check({31'h0, spi_mode}, 32'h0);
		$display("test_reset_state done");
	endtask

	task automatic test_i2c();
		run_cmd(KIND_WRITE, 1'b1, 8'h05, 3'h2, 32'h0000_c35a);
		nack_is(1'b0);
		// Pointer-only write must leave register 7 alone
		run_cmd(KIND_WRITE, 1'b1, 8'h07, 3'h0, 32'h0000_00ff);
		nack_is(1'b0);
		run_cmd(KIND_READ, 1'b1, 8'h05, 3'h3, 32'h0);
		nack_is(1'b0);
		check({8'h00, rsp_rdata[23:0]}, 32'h0000_c35a);
		run_cmd(KIND_READ, 1'b1, 8'h06, 3'h1, 32'h0);
		check({24'h0, rsp_rdata[7:0]}, 32'h0000_00c3);
		$display("test_i2c done");
	endtask

	task automatic test_foreign();
		run_cmd(KIND_WRITE, 1'b0, 8'h05, 3'h1, 32'h0000_00ff);
		nack_is(1'b1);
		run_cmd(KIND_READ, 1'b1, 8'h05, 3'h1, 32'h0);
		check({24'h0, rsp_rdata[7:0]}, 32'h0000_005a);
		@(posedge clk_in);
		strap <= 1'b0;
		run_cmd(2'h3, 1'b0, 8'h09, 3'h1, 32'h0000_0077);
		nack_is(1'b0);
		run_cmd(KIND_READ, 1'b0, 8'h09, 3'h1, 32'h0);
		check({24'h0, rsp_rdata[7:0]}, 32'h0000_0077);
		$display("test_foreign done");
	endtask

	task automatic test_spi();
		run_cmd(KIND_SPI, 1'b0, 8'h00, 3'h4, 32'ha5c3_1e96);
		check(rsp_rdata, SR_RESET);
		repeat (6) @(negedge clk_in);
		check(switch_w, 32'ha5c3_1e96);
		check({24'h0, switch_w[31:24]}, 32'h0000_00a5);
		check({31'h0, spi_mode}, 32'h0000_0001);
		run_cmd(KIND_SPI, 1'b0, 8'h00, 3'h4, 32'h0f0f_8001);
		check(rsp_rdata, 32'ha5c3_1e96);
		repeat (6) @(negedge clk_in);
		check(switch_w, 32'h0f0f_8001);
		$display("test_spi done");
	endtask

	task automatic test_shutdown();
		@(posedge clk_in);
		nrst_in <= 1'b0;
		repeat (48) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(negedge clk_in);
		check(switch_w, SR_RESET);
		check({31'h0, spi_mode}, 32'h0);
		run_cmd(KIND_SPI, 1'b0, 8'h00, 3'h4, 32'h1234_5678);
		check(rsp_rdata, SR_RESET);
		$display("test_shutdown done");
	endtask

	// ----------------------------------------
	// Clock, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever begin
			#20 clk_in = ~clk_in;
		end
	end

	initial begin
		nrst_in = 1'b0;
		strap = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = KIND_WRITE;
		cmd_dev = 1'b0;
		cmd_reg = 8'h00;
		cmd_len = 3'h0;
		cmd_wdata = 32'h0;
		err_count = 0;
		comparisons = 0;
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(negedge clk_in);
		test_reset_state();
		test_i2c();
		test_foreign();
		test_spi();
		test_shutdown();
		report_and_stop();
	end

	initial begin
		repeat (30000) @(posedge clk_in);
		err_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- bench/msw_link_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module msw_link_properties (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic scl,
	input wire logic cs_n,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic dev_do_out,
	input wire logic dev_do_oe,
	input wire logic sda
);
	// ----------------------------------------
	// Link checks, sampled in the system clock
	// ----------------------------------------
	// Scl comes from a host flop, so one fast domain sees every link edge
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	a_dev_sda_steady: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device SDA drive changed while SCL high");
	a_sda_one_owner: assert property (dev_sda_oe && host_sda_oe |-> !scl)
		else $error("both ends drive SDA while SCL high");
	a_start_by_host: assert property ($fell(sda) && scl |-> host_sda_oe)
		else $error("SDA fell under high SCL without host drive");
	a_drive_full_bit: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
		else $error("device SDA pull shorter than one bit");
	a_spi_no_sda: assert property (!cs_n |-> !dev_sda_oe)
		else $error("device pulls SDA while select is low");
	a_spi_latch_kept: assert property (dev_do_oe |=> dev_do_oe)
		else $error("serial-mode latch dropped without shutdown");
	a_latch_under_cs: assert property ($rose(dev_do_oe) |-> !cs_n)
		else $error("serial mode latched while select high");
	a_do_on_fall: assert property (
		dev_do_oe && $past(dev_do_oe) && $changed(dev_do_out) |-> !scl)
		else $error("serial output changed while SCL high");
	// Guard on reset history: the host toggles SCL every clock while reset is low
	a_scl_high_phase: assert property (
		$rose(scl) && $past(nrst_in) |-> scl[*6])
		else $error("SCL high phase too short");
	a_scl_low_phase: assert property (
		$fell(scl) && $past(nrst_in) |-> (!scl)[*6])
		else $error("SCL low phase too short");
endmodule
`default_nettype wire

// ---- rtl/msw_dev_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module msw_dev_end
	import msw_pkg::*;
#(
	parameter int REG_DEPTH = REG_DEPTH_DEF
)(
	input wire logic clk_in,
	input wire logic nrst_in,
	msw_link_if.dev lk,
	output logic [SW_COUNT-1:0] switch_out,
	output logic spi_mode_out
);
	localparam int IW = $clog2(REG_DEPTH);

	if (REG_DEPTH < 2 || REG_DEPTH > 256 || (1 << IW) != REG_DEPTH) begin
		$error("REG_DEPTH must be a power of two, 2 to 256");
	end

	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX = 5'h02,
		D_ACK = 5'h04,
		D_TX = 5'h08,
		D_MACK = 5'h10
	} msw_dstate_type;

	typedef struct packed {
		logic rst_m;
		logic rst_s;
		logic strap_m;
		logic strap_s;
		logic sda_hi;
		msw_dstate_type st;
		logic [1:0] kind;
		logic rd;
		logic [3:0] bit_cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic [REG_DEPTH-1:0][7:0] regs;
		logic [SW_COUNT-1:0] sr;
		logic [5:0] cnt;
		logic cs_seen_high;
		logic spi_mode;
		logic full;
	} msw_link_type;

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic cs_d;
		logic mode_m;
		logic mode_s;
		logic full_m;
		logic full_s;
		logic [SW_COUNT-1:0] sw;
	} msw_sys_type;

	msw_link_type lk_r;
	msw_link_type lk_nxt;
	msw_sys_type sy_r;
	msw_sys_type sy_nxt;
	logic neg_sda;
	logic drive_low;
	logic start_seen;
	logic [7:0] rx_byte;
	logic [5:0] cnt_nxt;

	// ----------------------------------------
	// Falling-edge stage for SDA and serial output
	// ----------------------------------------
	msw_edge_stage msw_edge_stage_i (
		.scl_in(lk.scl),
		.nrst_in(lk_r.rst_s),
		.sda_in(lk.sda),
		.drive_low_in(drive_low),
		.do_in(lk_r.sr[SW_COUNT-1]),
		.do_en_in(lk_r.spi_mode),
		.sda_seen_out(neg_sda),
		.sda_out(lk.dev_sda_out),
		.sda_oe_out(lk.dev_sda_oe),
		.do_out(lk.dev_do_out),
		.do_oe_out(lk.dev_do_oe)
	);

	// Open drain: only ever pull low, never drive high
	assign drive_low = (lk_r.st == D_ACK) ||
		(lk_r.st == D_TX && !lk_r.sh[7]);

	// SDA high at the rise, low at the fall: fell while SCL high
	assign start_seen = lk_r.sda_hi && !neg_sda;

	// ----------------------------------------
	// Link domain, clocked by the host serial clock
	// ----------------------------------------
	always_comb begin
		lk_nxt = lk_r;
		rx_byte = {lk_r.sh[6:0], lk.sda};
		cnt_nxt = lk_r.cnt;
		lk_nxt.rst_m = nrst_in;
		lk_nxt.rst_s = lk_r.rst_m;
		lk_nxt.strap_m = lk.add_do;
		lk_nxt.strap_s = lk_r.strap_m;
		lk_nxt.sda_hi = lk.sda;
		if (!lk_r.rst_s) begin
			lk_nxt.st = D_IDLE;
			lk_nxt.kind = BK_ADDR;
			lk_nxt.rd = 1'b0;
			lk_nxt.bit_cnt = '0;
			lk_nxt.sh = '0;
			lk_nxt.ptr = '0;
			lk_nxt.regs = {REG_DEPTH{REG_RESET}};
			lk_nxt.sr = SR_RESET;
			lk_nxt.cnt = '0;
			lk_nxt.cs_seen_high = 1'b1;
			lk_nxt.spi_mode = 1'b0;
			lk_nxt.full = 1'b0;
		end else begin
			if (lk.cs_n) begin
				// Count, full flag and shift register are kept; the other domain reads the last two
				lk_nxt.cs_seen_high = 1'b1;
			end else begin
				lk_nxt.sr = {lk_r.sr[SW_COUNT-2:0], lk.sda};
				if (lk_r.cs_seen_high) begin
					cnt_nxt = 6'h01;
				end else if (lk_r.cnt != CNT_MAX) begin
					cnt_nxt = lk_r.cnt + 6'h01;
				end
				lk_nxt.cnt = cnt_nxt;
				lk_nxt.cs_seen_high = 1'b0;
				lk_nxt.full = (cnt_nxt >= SPI_FULL_BITS);
				if (cnt_nxt >= MODE_CLOCKS) begin
					lk_nxt.spi_mode = 1'b1;
				end
			end
			if (!lk.cs_n || lk_r.spi_mode) begin
				lk_nxt.st = D_IDLE;
			end else if (start_seen) begin
				// This rise already carries the first address bit
				lk_nxt.st = D_RX;
				lk_nxt.kind = BK_ADDR;
				lk_nxt.bit_cnt = 4'h1;
				lk_nxt.sh = {7'h00, lk.sda};
			end else begin
				unique case (lk_r.st)
					D_IDLE: begin
						lk_nxt.st = D_IDLE;
					end
					D_RX: begin
						lk_nxt.sh = rx_byte;
						lk_nxt.bit_cnt = lk_r.bit_cnt + 4'h1;
						if (lk_r.bit_cnt == LAST_BIT) begin
							lk_nxt.st = D_ACK;
							if (lk_r.kind == BK_ADDR) begin
								lk_nxt.rd = rx_byte[0];
								if (rx_byte[7:1] != {I2C_ADDR_HI, lk_r.strap_s}) begin
									lk_nxt.st = D_IDLE;
								end
							end else if (lk_r.kind == BK_REG) begin
								lk_nxt.ptr = rx_byte;
							end else begin
								lk_nxt.regs[lk_r.ptr[IW-1:0]] = rx_byte;
								lk_nxt.ptr = lk_r.ptr + 8'h01;
							end
						end
					end
					D_ACK: begin
						lk_nxt.bit_cnt = '0;
						if (lk_r.kind == BK_ADDR && lk_r.rd) begin
							lk_nxt.st = D_TX;
							lk_nxt.sh = lk_r.regs[lk_r.ptr[IW-1:0]];
							lk_nxt.ptr = lk_r.ptr + 8'h01;
						end else begin
							lk_nxt.st = D_RX;
							lk_nxt.kind = (lk_r.kind == BK_ADDR) ? BK_REG : BK_DATA;
						end
					end
					D_TX: begin
						lk_nxt.sh = {lk_r.sh[6:0], 1'b0};
						lk_nxt.bit_cnt = lk_r.bit_cnt + 4'h1;
						if (lk_r.bit_cnt == LAST_BIT) begin
							lk_nxt.st = D_MACK;
						end
					end
					D_MACK: begin
						lk_nxt.bit_cnt = '0;
						if (!lk.sda) begin
							lk_nxt.st = D_TX;
							lk_nxt.sh = lk_r.regs[lk_r.ptr[IW-1:0]];
							lk_nxt.ptr = lk_r.ptr + 8'h01;
						end else begin
							lk_nxt.st = D_IDLE;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge lk.scl) begin
		lk_r <= lk_nxt;
	end

	// ----------------------------------------
	// System domain: switch update on select rise
	// ----------------------------------------
	// Shift register is quiet while select is high, so it is read
	// here only after the synchronised rise has been seen.
	always_comb begin
		sy_nxt = sy_r;
		sy_nxt.cs_m = lk.cs_n;
		sy_nxt.cs_s = sy_r.cs_m;
		sy_nxt.cs_d = sy_r.cs_s;
		sy_nxt.mode_m = lk_r.spi_mode;
		sy_nxt.mode_s = sy_r.mode_m;
		sy_nxt.full_m = lk_r.full;
		sy_nxt.full_s = sy_r.full_m;
		if (!nrst_in) begin
			sy_nxt = '0;
			sy_nxt.cs_m = 1'b1;
			sy_nxt.cs_s = 1'b1;
			sy_nxt.cs_d = 1'b1;
		end else if (sy_r.cs_s && !sy_r.cs_d && sy_r.mode_s &&
			sy_r.full_s) begin
			// Bit 31 down to 24 is bank D switch 8 to 1
			sy_nxt.sw = lk_r.sr;
		end
	end

	always_ff @(posedge clk_in) begin
		sy_r <= sy_nxt;
	end

	assign switch_out = sy_r.sw;
	assign spi_mode_out = sy_r.mode_s;
endmodule
`default_nettype wire

// ---- rtl/msw_edge_stage.sv ----
`timescale 1ns/1ns
`default_nettype none
module msw_edge_stage (
	input wire logic scl_in,
	input wire logic nrst_in,
	input wire logic sda_in,
	input wire logic drive_low_in,
	input wire logic do_in,
	input wire logic do_en_in,
	output logic sda_seen_out,
	output logic sda_out,
	output logic sda_oe_out,
	output logic do_out,
	output logic do_oe_out
);
	typedef struct packed {
		logic sda;
		logic oe;
		logic do_v;
		logic do_en;
	} msw_edge_type;

	msw_edge_type e_r;
	msw_edge_type e_nxt;

	// ----------------------------------------
	// Falling edge: outputs move only while SCL is low
	// ----------------------------------------
	always_comb begin
		e_nxt.sda = sda_in;
		e_nxt.oe = drive_low_in;
		e_nxt.do_v = do_in;
		e_nxt.do_en = do_en_in;
		if (!nrst_in) begin
			e_nxt = '0;
			e_nxt.sda = 1'b1;
		end
	end

	always_ff @(negedge scl_in) begin
		e_r <= e_nxt;
	end

	assign sda_seen_out = e_r.sda;
	assign sda_out = 1'b0;
	assign sda_oe_out = e_r.oe;
	assign do_out = e_r.do_v;
	assign do_oe_out = e_r.do_en;
endmodule
`default_nettype wire

// ---- rtl/msw_host_end.sv ----
`timescale 1ns/1ns
`default_nettype none
module msw_host_end
	import msw_pkg::*;
#(
	parameter int QUARTER = QUARTER_DEF,
	parameter int CHAIN_LEN = 1,
	localparam int DW = SW_COUNT * CHAIN_LEN
)(
	input wire logic clk_in,
	input wire logic nrst_in,
	msw_link_if.host lk,
	input wire logic cmd_valid_in,
	input wire logic [1:0] cmd_kind_in,
	input wire logic cmd_dev_in,
	input wire logic [7:0] cmd_reg_in,
	input wire logic [2:0] cmd_len_in,
	input wire logic [DW-1:0] cmd_wdata_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output logic rsp_nack_out,
	output logic [DW-1:0] rsp_rdata_out
);
	localparam int QW = $clog2(QUARTER) + 1;
	localparam int CW = $clog2(DW) + 1;

	if (QUARTER < 3 || CHAIN_LEN < 1 || CHAIN_LEN > 8) begin
		$error("QUARTER must be 3 or more, CHAIN_LEN 1 to 8");
	end

	typedef enum logic [6:0] {
		H_IDLE = 7'h01,
		H_START = 7'h02,
		H_TX = 7'h04,
		H_RX = 7'h08,
		H_STOP = 7'h10,
		H_SPI = 7'h20,
		H_SPIEND = 7'h40
	} msw_hstate_type;

	typedef struct packed {
		msw_hstate_type st;
		logic [1:0] ph;
		logic [QW-1:0] qcnt;
		logic scl;
		logic cs_n;
		logic sda_out;
		logic sda_oe;
		logic sda_m;
		logic sda_s;
		logic do_m;
		logic do_s;
		logic [2:0] stg;
		logic [3:0] bit_n;
		logic [7:0] tx;
		logic [7:0] rxb;
		logic [2:0] byte_n;
		logic [1:0] kind;
		logic dev;
		logic [7:0] reg_a;
		logic [2:0] len;
		logic [DW-1:0] wdat;
		logic [DW-1:0] rdat;
		logic [CW-1:0] spi_n;
		logic nack;
		logic ready;
		logic rsp_v;
		logic rlow;
		logic [1:0] wake;
	} msw_host_type;

	msw_host_type h_r;
	msw_host_type h_nxt;
	logic tick;
	logic [DW-1:0] byte_sel;
	logic [DW-1:0] wide;

	always_comb begin
		h_nxt = h_r;
		tick = (h_r.qcnt == QW'(QUARTER - 1));
		byte_sel = h_r.wdat >> {h_r.byte_n, 3'h0};
		wide = DW'(h_r.rxb) << {h_r.byte_n, 3'h0};
		h_nxt.sda_m = lk.sda;
		h_nxt.sda_s = h_r.sda_m;
		h_nxt.do_m = lk.add_do;
		h_nxt.do_s = h_r.do_m;
		h_nxt.rsp_v = 1'b0;
		h_nxt.rlow = !nrst_in;
		h_nxt.qcnt = tick ? '0 : h_r.qcnt + QW'(1);
		if (!nrst_in) begin
			// Clock keeps running so the device side can reset
			h_nxt.st = H_IDLE;
			h_nxt.qcnt = '0;
			h_nxt.ph = '0;
			h_nxt.wake = WAKE_PERIODS;
			if (h_r.rlow) begin
				h_nxt.scl = !h_r.scl;
			end else begin
				h_nxt.scl = 1'b1;
			end
			h_nxt.cs_n = 1'b1;
			h_nxt.sda_oe = 1'b0;
			h_nxt.ready = 1'b0;
			h_nxt.nack = 1'b0;
			h_nxt.rdat = '0;
		end else if (h_r.st == H_IDLE) begin
			h_nxt.cs_n = 1'b1;
			h_nxt.sda_oe = 1'b0;
			if (h_r.wake != 2'h0) begin
				// Device reset sync drains only on SCL rises
				h_nxt.ready = 1'b0;
				if (tick) begin
					h_nxt.ph = h_r.ph + 2'h1;
					if (h_r.ph == 2'h0) begin
						h_nxt.scl = 1'b0;
					end else if (h_r.ph == 2'h2) begin
						h_nxt.scl = 1'b1;
					end else if (h_r.ph == 2'h3) begin
						h_nxt.wake = h_r.wake - 2'h1;
					end
				end
			end else begin
				h_nxt.scl = 1'b1;
				h_nxt.ready = 1'b1;
				if (cmd_valid_in && h_r.ready) begin
					h_nxt.ready = 1'b0;
					h_nxt.ph = '0;
					h_nxt.qcnt = '0;
					h_nxt.kind = cmd_kind_in;
					h_nxt.dev = cmd_dev_in;
					h_nxt.reg_a = cmd_reg_in;
					h_nxt.len = cmd_len_in;
					h_nxt.wdat = cmd_wdata_in;
					h_nxt.rdat = '0;
					h_nxt.nack = 1'b0;
					h_nxt.stg = 3'h0;
					h_nxt.byte_n = '0;
					h_nxt.spi_n = '0;
					if (cmd_kind_in == KIND_SPI) begin
						h_nxt.st = H_SPI;
						h_nxt.cs_n = 1'b0;
					end else begin
						h_nxt.st = H_START;
					end
				end
			end
		end else if (tick) begin
			// ----------------------------------------
			// Quarter phases: SCL low, data, SCL high, sample
			// ----------------------------------------
			h_nxt.ph = h_r.ph + 2'h1;
			if (h_r.ph == 2'h0) begin
				h_nxt.scl = 1'b0;
			end else if (h_r.ph == 2'h2) begin
				h_nxt.scl = 1'b1;
			end
			h_nxt.sda_out = 1'b0;
			unique case (h_r.st)
				H_START: begin
					if (h_r.ph == 2'h1) begin
						h_nxt.sda_oe = 1'b0;
					end else if (h_r.ph == 2'h3) begin
						h_nxt.sda_oe = 1'b1;
						h_nxt.st = H_TX;
						h_nxt.bit_n = '0;
						h_nxt.tx = {I2C_ADDR_HI, h_r.dev, h_r.stg == 3'h3};
					end
				end
				H_TX: begin
					if (h_r.ph == 2'h1) begin
						h_nxt.sda_oe = (h_r.bit_n != ACK_BIT) && !h_r.tx[7];
					end else if (h_r.ph == 2'h3) begin
						h_nxt.bit_n = h_r.bit_n + 4'h1;
						h_nxt.tx = {h_r.tx[6:0], 1'b0};
						if (h_r.bit_n == ACK_BIT) begin
							h_nxt.bit_n = '0;
							if (h_r.sda_s) begin
								h_nxt.nack = 1'b1;
								h_nxt.st = H_STOP;
							end else if (h_r.stg == 3'h0) begin
								h_nxt.stg = 3'h1;
								h_nxt.tx = h_r.reg_a;
							end else if (h_r.stg == 3'h3) begin
								h_nxt.stg = 3'h4;
								h_nxt.byte_n = '0;
								h_nxt.st = (h_r.len == 3'h0) ? H_STOP : H_RX;
							end else if (h_r.kind == KIND_READ && h_r.stg == 3'h1) begin
								h_nxt.stg = 3'h3;
								h_nxt.st = (h_r.len == 3'h0) ? H_STOP : H_START;
							end else if (h_r.byte_n == h_r.len) begin
								h_nxt.st = H_STOP;
							end else begin
								h_nxt.stg = 3'h2;
								h_nxt.tx = byte_sel[7:0];
								h_nxt.byte_n = h_r.byte_n + 3'h1;
							end
						end
					end
				end
				H_RX: begin
					if (h_r.ph == 2'h1) begin
						h_nxt.sda_oe = (h_r.bit_n == ACK_BIT) &&
							(h_r.byte_n + 3'h1 != h_r.len);
					end else if (h_r.ph == 2'h3) begin
						h_nxt.bit_n = h_r.bit_n + 4'h1;
						if (h_r.bit_n != ACK_BIT) begin
							h_nxt.rxb = {h_r.rxb[6:0], h_r.sda_s};
						end else begin
							h_nxt.rdat = h_r.rdat | wide;
							h_nxt.byte_n = h_r.byte_n + 3'h1;
							h_nxt.bit_n = '0;
							if (h_r.byte_n + 3'h1 == h_r.len) begin
								h_nxt.st = H_STOP;
							end
						end
					end
				end
				H_STOP: begin
					if (h_r.ph == 2'h1) begin
						h_nxt.sda_oe = 1'b1;
					end else if (h_r.ph == 2'h3) begin
						h_nxt.sda_oe = 1'b0;
						h_nxt.st = H_IDLE;
						h_nxt.rsp_v = 1'b1;
					end
				end
				H_SPI: begin
					if (h_r.ph == 2'h1) begin
						h_nxt.sda_oe = 1'b1;
						h_nxt.sda_out = h_r.wdat[DW-1];
					end else if (h_r.ph == 2'h3) begin
						h_nxt.sda_oe = 1'b1;
						h_nxt.sda_out = h_r.wdat[DW-1];
						h_nxt.rdat = {h_r.rdat[DW-2:0], h_r.do_s};
						h_nxt.wdat = {h_r.wdat[DW-2:0], 1'b0};
						h_nxt.spi_n = h_r.spi_n + CW'(1);
						if (h_r.spi_n == CW'(DW - 1)) begin
							h_nxt.st = H_SPIEND;
						end
					end else begin
						h_nxt.sda_oe = 1'b1;
						h_nxt.sda_out = h_r.sda_out;
					end
				end
				H_SPIEND: begin
					if (h_r.ph == 2'h1) begin
						// Extra pulse with select high marks the frame end
						h_nxt.cs_n = 1'b1;
						h_nxt.sda_oe = 1'b0;
					end else if (h_r.ph == 2'h3) begin
						h_nxt.st = H_IDLE;
						h_nxt.rsp_v = 1'b1;
					end
				end
				H_IDLE: begin
					h_nxt.st = H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		h_r <= h_nxt;
	end

	assign lk.scl = h_r.scl;
	assign lk.cs_n = h_r.cs_n;
	assign lk.host_sda_out = h_r.sda_out;
	assign lk.host_sda_oe = h_r.sda_oe;
	assign cmd_ready_out = h_r.ready;
	assign rsp_valid_out = h_r.rsp_v;
	assign rsp_nack_out = h_r.nack;
	assign rsp_rdata_out = h_r.rdat;
endmodule
`default_nettype wire

// ---- rtl/msw_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface msw_link_if;
	logic scl;
	logic cs_n;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic dev_do_out;
	logic dev_do_oe;
	logic addr_strap;
	logic sda;
	logic add_do;

	// Open drain with pull-up; host drives push-pull as DI in SPI
	assign sda = host_sda_oe ? host_sda_out :
		(dev_sda_oe ? dev_sda_out : 1'b1);
	assign add_do = dev_do_oe ? dev_do_out : addr_strap;

	modport host (
		output scl,
		output cs_n,
		output host_sda_out,
		output host_sda_oe,
		input sda,
		input add_do
	);
	modport dev (
		input scl,
		input cs_n,
		input sda,
		input add_do,
		output dev_sda_out,
		output dev_sda_oe,
		output dev_do_out,
		output dev_do_oe
	);
endinterface
`default_nettype wire

// ---- rtl/msw_pkg.sv ----
package msw_pkg;
	// ----------------------------------------
	// Switch array and two-wire addressing
	// ----------------------------------------
	localparam int SW_COUNT = 32;
	localparam logic [5:0] I2C_ADDR_HI = 6'h3a;
	localparam int REG_DEPTH_DEF = 32;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [31:0] SR_RESET = 32'h0000_0000;
	localparam logic [5:0] MODE_CLOCKS = 6'h15;
	localparam logic [5:0] SPI_FULL_BITS = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [1:0] WAKE_PERIODS = 2'h3;

	// Kind of byte the device is receiving
	localparam logic [1:0] BK_ADDR = 2'h0;
	localparam logic [1:0] BK_REG = 2'h1;
	localparam logic [1:0] BK_DATA = 2'h2;

	// ----------------------------------------
	// Host command kinds and timing
	// ----------------------------------------
	localparam logic [1:0] KIND_WRITE = 2'h0;
	localparam logic [1:0] KIND_READ = 2'h1;
	localparam logic [1:0] KIND_SPI = 2'h2;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int QUARTER_DEF = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
endpackage
